// file: logic/bssc_pkg.sv
// package of constants and types for the block-transfer start/status control
// Notes on behaviour
// - with auto-start set, a trigger write launches a transfer from buffered parameters
// - with auto-start clear, a trigger write does not launch; start bit does
// - buffered set holds expand colours, geometry, pitch, addresses, mode and raster op
// - trigger write during a running transfer with auto-start posts a pending start
// - buffer flag reads 0 when free; clears on engine reset and transfer start; a trigger write that launches in its own cycle leaves it set
// - buffer flag reads 1 when loaded; sets on write per selected silicon revision
// - reset-status sets at start, clears on engine reset, stays set when suspended
// - engine reset aborts transfer at once, clears reset-status and buffer flags
// - explicit start begins transfer at next memory cycle granted to engine
// - explicit start bit clears itself when the transfer completes with no start pending
// - clearing start suspends at scanline end; height shows completed line count
// - setting start again resumes a suspended transfer where it stopped
// - busy reads 1 while a transfer runs or is suspended, 0 when idle
// - raster-op register holds eight-bit code, resets to low four bits set
package bssc_pkg;
  // ----------------------------------------
  // register indices on the indexed port
  // ----------------------------------------
  localparam logic [7:0] IDX_EXP_BG = 8'h00;
  localparam logic [7:0] IDX_EXP_FG = 8'h01;
  localparam logic [7:0] IDX_EXP_BG_HI = 8'h10;
  localparam logic [7:0] IDX_EXP_FG_HI = 8'h11;
  localparam logic [7:0] IDX_CTL_FIRST = 8'h20;
  localparam logic [7:0] IDX_HEIGHT_LO = 8'h22;
  localparam logic [7:0] IDX_HEIGHT_HI = 8'h23;
  localparam logic [7:0] IDX_TRIGGER = 8'h2A;
  localparam logic [7:0] IDX_SRC_FIRST = 8'h2C;
  localparam logic [7:0] IDX_SRC_LAST = 8'h2E;
  localparam logic [7:0] IDX_MODE = 8'h30;
  localparam logic [7:0] IDX_START_STATUS = 8'h31;
  localparam logic [7:0] IDX_RASTER_OP = 8'h32;
  // ----------------------------------------
  // start/status field positions and resets
  // ----------------------------------------
  localparam int BIT_AUTO_START = 7;
  localparam int BIT_BUFFER_FULL = 4;
  localparam int BIT_RESET_STATUS = 3;
  localparam int BIT_SOFT_RESET = 2;
  localparam int BIT_START = 1;
  localparam int BIT_BUSY = 0;
  localparam logic RST_AUTO_START = 1'b1;
  localparam logic RST_SOFT_RESET = 1'b1;
  localparam logic RST_BUFFER_FULL = 1'b1;
  localparam logic RST_RESET_STATUS = 1'b1;
  localparam logic RST_START = 1'b1;
  localparam logic RST_BUSY = 1'b1;
  localparam logic [7:0] RST_RASTER_OP = 8'h0F;
  localparam int HEIGHT_W = 11;

  // host access on the indexed data port
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] index;
    logic [7:0] wdata;
  } bssc_host_s;

  // engine engine-control state
  typedef enum logic [1:0] {
    BSSC_IDLE,
    BSSC_RUN,
    BSSC_SUSPEND
  } bssc_state_e;
endpackage

// file: logic/bssc_blit_control.sv
// start, suspend, reset and status control of the block-transfer engine
`timescale 1ns/1ps
module bssc_blit_control
  import bssc_pkg::*;
#(
  parameter int NUM_PARAMS = 51,
  parameter bit LATE_REVISION = 1'b1
) (
  input wire logic clk,
  input wire logic reset,
  input wire bssc_host_s host,
  output logic [7:0] rdata,
  output logic rdata_valid,
  input wire logic mem_grant,
  input wire logic line_done,
  input wire logic xfer_done,
  output logic engine_run,
  output logic engine_load,
  output logic engine_abort,
  output logic [NUM_PARAMS*8-1:0] working_set,
  output logic [7:0] raster_op_select
);
  // ----------------------------------------
  // host decode
  // ----------------------------------------
  function automatic logic is_buffered(input logic [7:0] idx);
    is_buffered = (idx == IDX_EXP_BG) || (idx == IDX_EXP_FG) ||
                  (idx == IDX_EXP_BG_HI) || (idx == IDX_EXP_FG_HI) ||
                  (idx >= IDX_CTL_FIRST && idx <= IDX_TRIGGER) ||
                  (idx >= IDX_SRC_FIRST && idx <= IDX_SRC_LAST) ||
                  (idx == IDX_MODE) || (idx == IDX_RASTER_OP);
  endfunction

  // slot of a buffered index in the flat parameter array
  function automatic logic [5:0] slot_of(input logic [7:0] idx);
    if (idx == IDX_EXP_BG) begin
      slot_of = 6'h00;
    end else if (idx == IDX_EXP_FG) begin
      slot_of = 6'h01;
    end else if (idx == IDX_EXP_BG_HI) begin
      slot_of = 6'h02;
    end else if (idx == IDX_EXP_FG_HI) begin
      slot_of = 6'h03;
    end else begin
      slot_of = 6'(idx - IDX_CTL_FIRST + 8'h04);
    end
  endfunction

  wire wr_buf = host.wr && is_buffered(host.index);
  wire wr_trig = host.wr && (host.index == IDX_TRIGGER);
  wire wr_ctl = host.wr && (host.index == IDX_START_STATUS);
  wire set_rst = wr_ctl && host.wdata[BIT_SOFT_RESET];
  wire [5:0] wr_slot = slot_of(host.index);

  // ----------------------------------------
  // control and status state
  // ----------------------------------------
  logic auto_start_enable;
  logic engine_soft_reset;
  logic explicit_start_bit;
  logic buffer_full_flag;
  logic reset_status_flag;
  logic busy_flag;
  logic pending_start;
  logic [7:0] param_buf [NUM_PARAMS];
  logic [HEIGHT_W-1:0] lines_done;
  bssc_state_e state;
  bssc_state_e next_state;

  // auto-start trigger only counts when the engine is out of reset
  wire trig_launch = wr_trig && auto_start_enable && !engine_soft_reset;
  // a set start bit keeps asking until a memory cycle is granted, so no start is lost
  wire start_req = (wr_ctl ? host.wdata[BIT_START] : explicit_start_bit) || trig_launch ||
                   pending_start;
  // a start only goes ahead on a memory cycle granted to the engine
  wire do_launch = (state == BSSC_IDLE) && start_req && mem_grant && !engine_soft_reset &&
                   !set_rst;
  wire do_resume = (state == BSSC_SUSPEND) && explicit_start_bit && mem_grant;
  wire do_suspend = (state == BSSC_RUN) && !explicit_start_bit && line_done;
  wire do_finish = (state == BSSC_RUN) && xfer_done;

  // engine state transitions
  always_comb begin
    next_state = state;
    case (state)
      BSSC_IDLE: begin
        if (do_launch) begin
          next_state = BSSC_RUN;
        end
      end
      BSSC_RUN: begin
        if (do_finish) begin
          next_state = BSSC_IDLE;
        end else if (do_suspend) begin
          next_state = BSSC_SUSPEND;
        end
      end
      BSSC_SUSPEND: begin
        if (do_resume) begin
          next_state = BSSC_RUN;
        end
      end
      default: next_state = BSSC_IDLE;
    endcase
    if (engine_soft_reset || set_rst) begin
      next_state = BSSC_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= BSSC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // buffered parameters and working copy
  // ----------------------------------------
  // buffered writes land in the front copy so the next job can load while one runs
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < NUM_PARAMS; i++) begin
        param_buf[i] <= 8'h00;
      end
      param_buf[int'(slot_of(IDX_RASTER_OP))] <= RST_RASTER_OP;
    end else if (wr_buf) begin
      param_buf[int'(wr_slot)] <= host.wdata;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_PARAMS; g++) begin : g_work
      always_ff @(posedge clk) begin
        if (reset) begin
          working_set[g*8 +: 8] <= 8'h00;
        end else if (do_launch) begin
          working_set[g*8 +: 8] <= param_buf[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // start/status bits
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      auto_start_enable <= RST_AUTO_START;
      engine_soft_reset <= RST_SOFT_RESET;
      explicit_start_bit <= RST_START;
      buffer_full_flag <= RST_BUFFER_FULL;
      reset_status_flag <= RST_RESET_STATUS;
      busy_flag <= RST_BUSY;
      pending_start <= 1'b0;
    end else begin
      if (wr_ctl) begin
        auto_start_enable <= host.wdata[BIT_AUTO_START];
        engine_soft_reset <= host.wdata[BIT_SOFT_RESET];
      end
      // start bit: host write, then self-clear on completion unless a start is pending
      if (engine_soft_reset || set_rst) begin
        explicit_start_bit <= 1'b0;
      end else if (wr_ctl) begin
        explicit_start_bit <= host.wdata[BIT_START];
      end else if (trig_launch) begin
        explicit_start_bit <= 1'b1;
      end else if (do_finish && !pending_start) begin
        explicit_start_bit <= 1'b0;
      end
      // trigger during a run posts one more start; cleared when it launches
      if (engine_soft_reset || set_rst) begin
        pending_start <= 1'b0;
      end else if (trig_launch && state != BSSC_IDLE) begin
        pending_start <= 1'b1;
      end else if (do_launch) begin
        pending_start <= 1'b0;
      end
      // buffer flag: set (revision choice) wins over the start clear
      if (engine_soft_reset || set_rst) begin
        buffer_full_flag <= 1'b0;
      end else if (LATE_REVISION ? wr_trig : wr_buf) begin
        buffer_full_flag <= 1'b1;
      end else if (do_launch) begin
        buffer_full_flag <= 1'b0;
      end
      if (engine_soft_reset || set_rst) begin
        reset_status_flag <= 1'b0;
      end else if (do_launch) begin
        reset_status_flag <= 1'b1;
      end
      busy_flag <= (next_state != BSSC_IDLE);
    end
  end

  // ----------------------------------------
  // line counter for height readback
  // ----------------------------------------
  // counts finished scanlines of the current job; a suspend freezes it
  always_ff @(posedge clk) begin
    if (reset || set_rst) begin
      lines_done <= '0;
    end else if (do_launch) begin
      lines_done <= '0;
    end else if (state == BSSC_RUN && line_done) begin
      lines_done <= lines_done + 1'b1;
    end
  end

  // ----------------------------------------
  // readback and engine outputs
  // ----------------------------------------
  wire [7:0] status_word = {auto_start_enable, 2'b00, buffer_full_flag, reset_status_flag,
                            engine_soft_reset, explicit_start_bit, busy_flag};
  wire [7:0] rd_mux =
    (host.index == IDX_START_STATUS) ? status_word :
    (host.index == IDX_HEIGHT_LO) ? lines_done[7:0] :
    (host.index == IDX_HEIGHT_HI) ? {5'b00000, lines_done[HEIGHT_W-1:8]} :
    is_buffered(host.index) ? param_buf[int'(wr_slot)] : 8'h00;

  always_ff @(posedge clk) begin
    if (reset) begin
      rdata <= 8'h00;
      rdata_valid <= 1'b0;
      engine_run <= 1'b0;
      engine_load <= 1'b0;
      engine_abort <= 1'b0;
      raster_op_select <= RST_RASTER_OP;
    end else begin
      rdata <= host.rd ? rd_mux : rdata;
      rdata_valid <= host.rd;
      engine_run <= (next_state == BSSC_RUN);
      engine_load <= do_launch;
      engine_abort <= set_rst && (state != BSSC_IDLE);
      raster_op_select <= param_buf[int'(slot_of(IDX_RASTER_OP))];
    end
  end
endmodule

// file: testbench/bssc_blit_control_monitor.sv
// checker of the block-transfer start/status control ports
`timescale 1ns/1ps
module bssc_blit_control_monitor
  import bssc_pkg::*;
#(
  parameter int NUM_PARAMS = 51
) (
  input wire logic clk,
  input wire logic reset,
  input wire bssc_host_s host,
  input wire logic [7:0] rdata,
  input wire logic rdata_valid,
  input wire logic mem_grant,
  input wire logic line_done,
  input wire logic xfer_done,
  input wire logic engine_run,
  input wire logic engine_load,
  input wire logic engine_abort,
  input wire logic [NUM_PARAMS*8-1:0] working_set,
  input wire logic [7:0] raster_op_select
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // write decodes; a soft reset write must keep the engine stopped for three cycles
  wire soft_wr = host.wr && host.index == IDX_START_STATUS && host.wdata[BIT_SOFT_RESET];
  wire rop_wr = host.wr && host.index == IDX_RASTER_OP;
  read_answer_a: assert property (host.rd |=> rdata_valid) else $error("read not answered");
  read_hold_a: assert property (!rdata_valid |-> $stable(rdata)) else $error("rdata moved");
  launch_grant_a: assert property ($rose(engine_run) |-> $past(mem_grant))
    else $error("run began without a memory grant");
  load_run_a: assert property (engine_load |-> engine_run) else $error("load while idle");
  abort_stop_a: assert property (engine_abort |-> !engine_run) else $error("abort kept run");
  soft_stop_a: assert property (soft_wr |-> ##2 !engine_run [*3])
    else $error("engine ran under soft reset");
  rop_load_a: assert property (rop_wr |-> ##2 raster_op_select == $past(host.wdata, 2))
    else $error("raster op not written");
  done_stop_a: assert property (engine_run && xfer_done && !mem_grant |=> !engine_run)
    else $error("run after completion");
  cover property (engine_load);
  cover property (engine_abort);
  cover property ($fell(engine_run) && !$past(xfer_done));
endmodule

bind bssc_blit_control bssc_blit_control_monitor #(.NUM_PARAMS(NUM_PARAMS)) i_mon (
  .clk(clk), .reset(reset), .host(host), .rdata(rdata), .rdata_valid(rdata_valid),
  .mem_grant(mem_grant), .line_done(line_done), .xfer_done(xfer_done),
  .engine_run(engine_run), .engine_load(engine_load), .engine_abort(engine_abort),
  .working_set(working_set), .raster_op_select(raster_op_select));

// file: testbench/bssc_blit_control_tb.sv
// self-checking bench of the block-transfer start/status control
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_errors++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module bssc_blit_control_tb
  import bssc_pkg::*;
;
  logic clk = 1'b0;
  logic reset = 1'b1;
  bssc_host_s host = '0;
  logic mem_grant = 1'b1;
  logic line_done = 1'b0;
  logic xfer_done = 1'b0;
  logic [7:0] rdata, raster_op_select;
  logic rdata_valid, engine_run, engine_load, engine_abort;
  logic [51*8-1:0] working_set;
  int n_errors = 0;
  int check_count = 0;
  int cycles = 0;
  bssc_blit_control i_dut (.clk(clk), .reset(reset), .host(host), .rdata(rdata),
    .rdata_valid(rdata_valid), .mem_grant(mem_grant), .line_done(line_done),
    .xfer_done(xfer_done), .engine_run(engine_run), .engine_load(engine_load),
    .engine_abort(engine_abort), .working_set(working_set),
    .raster_op_select(raster_op_select));
  initial forever #2 clk = ~clk;
  // the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  // ----------------------------------------
  // host port cycles
  // ----------------------------------------
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    @(posedge clk) host <= '{wr: 1'b1, rd: 1'b0, index: i, wdata: d};
    @(posedge clk) host <= '0;
  endtask
  task automatic rd(input logic [7:0] i, output logic [7:0] v);
    @(posedge clk) host <= '{wr: 1'b0, rd: 1'b1, index: i, wdata: 8'h00};
    @(posedge clk) host <= '0;
    #1 v = rdata;
    `CHK("read answer", 1'b1, rdata_valid)
  endtask
  task automatic pulse_done(input bit line);
    @(posedge clk) {line_done, xfer_done} <= {line, !line};
    @(posedge clk) {line_done, xfer_done} <= 2'b00;
  endtask
  // bounded wait, looking first just after the current edge so a one-cycle pulse is not missed
  // sel 0 run high, 1 load pulse, 2 run low, 3 abort pulse
  task automatic wait_for(input int sel, output logic hit);
    hit = 1'b0;
    repeat (8) begin
      #1;
      if ((sel == 0 && engine_run) || (sel == 1 && engine_load) ||
          (sel == 2 && !engine_run) || (sel == 3 && engine_abort)) begin
        hit = 1'b1;
        break;
      end
      @(posedge clk);
    end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    logic [7:0] v;
    rd(IDX_START_STATUS, v);
    // engine reset bit still set, so start, buffer and reset-status flags are held clear
    `CHK("reset status", 8'h84, v)
    `CHK("reset raster op", 8'h0F, raster_op_select)
    wr(IDX_RASTER_OP, 8'hA5);
    rd(IDX_RASTER_OP, v);
    `CHK("raster op read", 8'hA5, v)
    $display("test reset done");
  endtask
  task automatic t_explicit();
    logic [7:0] v;
    logic hit;
    wr(IDX_START_STATUS, 8'h00);
    @(posedge clk) mem_grant <= 1'b0;
    wr(IDX_START_STATUS, 8'h02);
    wait_for(0, hit);
    `CHK("run without grant", 1'b0, hit)
    @(posedge clk) mem_grant <= 1'b1;
    wait_for(0, hit);
    `CHK("run after grant", 1'b1, hit)
    rd(IDX_START_STATUS, v);
    `CHK("started status", 5'h0B, v[4:0])
    pulse_done(1'b0);
    rd(IDX_START_STATUS, v);
    `CHK("done status", 5'h08, v[4:0])
    wr(IDX_TRIGGER, 8'h1F);
    wait_for(0, hit);
    `CHK("trigger with auto off", 1'b0, hit)
    rd(IDX_START_STATUS, v);
    `CHK("buffer flag", 1'b1, v[BIT_BUFFER_FULL])
    $display("test explicit done");
  endtask
  task automatic t_auto();
    logic hit;
    wr(IDX_START_STATUS, 8'h80);
    wr(IDX_EXP_BG, 8'h5A);
    wr(IDX_RASTER_OP, 8'h3C);
    wr(IDX_TRIGGER, 8'h15);
    wait_for(1, hit);
    `CHK("auto launch", 1'b1, hit)
    `CHK("working colour", 8'h5A, working_set[7:0])
    `CHK("working raster op", 8'h3C, working_set[22*8+:8])
    wr(IDX_EXP_BG, 8'hC3);
    wr(IDX_TRIGGER, 8'h15);
    `CHK("working held", 8'h5A, working_set[7:0])
    pulse_done(1'b0);
    wait_for(1, hit);
    `CHK("posted relaunch", 1'b1, hit)
    `CHK("next colour", 8'hC3, working_set[7:0])
    pulse_done(1'b0);
    wait_for(2, hit);
    `CHK("idle after last", 1'b1, hit)
    $display("test auto done");
  endtask
  task automatic t_suspend();
    logic [7:0] v;
    logic hit;
    wr(IDX_TRIGGER, 8'h15);
    wait_for(0, hit);
    wr(IDX_START_STATUS, 8'h80);
    pulse_done(1'b1);
    wait_for(2, hit);
    `CHK("suspend at line end", 1'b1, hit)
    rd(IDX_START_STATUS, v);
    `CHK("suspended status", 4'h9, v[3:0])
    rd(IDX_HEIGHT_LO, v);
    `CHK("lines done", 8'h01, v)
    wr(IDX_START_STATUS, 8'h82);
    wait_for(0, hit);
    `CHK("resume", 1'b1, hit)
    wr(IDX_START_STATUS, 8'h84);
    wait_for(3, hit);
    `CHK("abort pulse", 1'b1, hit)
    rd(IDX_START_STATUS, v);
    `CHK("after soft reset", 2'b00, v[4:3])
    $display("test suspend done");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_explicit();
    t_auto();
    t_suspend();
    tally_and_finish();
  end
endmodule
